// file: hdl/ppbc_port_control.sv
// Port transceiver control register with its serial management slave.
`timescale 1ns/1ps
// Summary of operation
// - Soft reset by management write restores defaults, then self-clears.
// - Loopback returns fabric transmissions, none to line.
// - Forced speed bit selects 10 or 100.
// - Autoneg enable overrides forced speed and duplex.
// - Power down bit places port in power-down.
// - Restart bit restarts negotiation and self-clears.
// - Forced duplex bit selects half or full.
// - Collision test asserts collision during transmission.
// - Speed default is negotiation OR speed strap.
// - Autoneg default equals negotiation strap.
// - Duplex default is not-negotiation AND duplex strap.
// - Loader overwrites register after reset or reload.
// - Sixteen-bit register at index zero, defaults from straps.
module ppbc_port_control (
    input  wire logic        ref_clk,
    input  wire logic        rst,
    input  wire logic [4:0]  phyAddr,
    input  wire logic        mdc,
    input  wire logic        mdioIn,
    output logic             mdioOut,
    output logic             mdioOe_n,
    input  wire logic        autonegStrap,
    input  wire logic        speedStrap,
    input  wire logic        duplexStrap,
    input  wire logic        loadValid,
    input  wire logic [15:0] loadData,
    input  wire logic        anSpeed100,
    input  wire logic        anFullDuplex,
    input  wire logic        fabricTxActive,
    output logic             lineTxEnable,
    output logic             fabricRxLoop,
    output logic             collision,
    output logic             speed100,
    output logic             fullDuplex,
    output logic             autonegEnable,
    output logic             autonegRestart,
    output logic             powerDown,
    output logic             portSoftReset
);
    typedef struct packed {
        ppbc_pkg::ppbc_state_t st;
        logic                  mdcPrev;
        logic [5:0]            cnt;
        logic [12:0]           hdr;
        logic [15:0]           shf;
        logic                  mdo;
        logic                  mdoeN;
        logic                  wrEn;
        logic [15:0]           wrData;
        logic                  txLine;
        logic                  rxLoop;
        logic                  col;
        logic                  spd;
        logic                  dup;
        logic                  ane;
        logic                  anr;
        logic                  pwd;
        logic                  srst;
    } ppbc_top_t;

    ppbc_top_t   s_r;
    ppbc_top_t   s_nxt;
    logic [15:0] ctrl;
    logic        softResetPulse;
    logic        anRestartPulse;
    logic        mdcRise;
    logic [12:0] hdrNxt;
    logic        isRead;
    logic        isOurs;

    ppbc_ctrl_reg u_ctrl_reg (
        .ref_clk        (ref_clk),
        .rst            (rst),
        .autonegStrap   (autonegStrap),
        .speedStrap     (speedStrap),
        .duplexStrap    (duplexStrap),
        .loadValid      (loadValid),
        .loadData       (loadData),
        .wrEn           (s_r.wrEn),
        .wrData         (s_r.wrData),
        .ctrl           (ctrl),
        .softResetPulse (softResetPulse),
        .anRestartPulse (anRestartPulse)
    );

    always_comb
    begin
        mdcRise = mdc & ~s_r.mdcPrev;
        hdrNxt  = {s_r.hdr[11:0], mdioIn};
        isRead  = s_r.hdr[11:10] == ppbc_pkg::OP_READ;
        isOurs  = s_r.hdr[9:5] == phyAddr;
        s_nxt         = s_r;
        s_nxt.mdcPrev = mdc;
        s_nxt.wrEn    = 1'b0;
        if (mdcRise)
        begin
            case (s_r.st)
                ppbc_pkg::ST_PRE:
                begin
                    if (mdioIn)
                    begin
                        if (s_r.cnt != ppbc_pkg::PREAMBLE_LEN)
                        begin
                            s_nxt.cnt = s_r.cnt + 6'h01;
                        end
                    end
                    else if (s_r.cnt == ppbc_pkg::PREAMBLE_LEN)
                    begin
                        s_nxt.st  = ppbc_pkg::ST_HDR;
                        s_nxt.cnt = '0;
                    end
                    else
                    begin
                        s_nxt.cnt = '0;
                    end
                end
                ppbc_pkg::ST_HDR:
                begin
                    s_nxt.hdr = hdrNxt;
                    s_nxt.cnt = s_r.cnt + 6'h01;
                    if (s_r.cnt == ppbc_pkg::HDR_LAST)
                    begin
                        s_nxt.cnt = '0;
                        s_nxt.st  = ppbc_pkg::ST_IDLE;
                        if (hdrNxt[12] && hdrNxt[9:5] == phyAddr &&
                            (hdrNxt[11:10] == ppbc_pkg::OP_READ ||
                             hdrNxt[11:10] == ppbc_pkg::OP_WRITE))
                        begin
                            s_nxt.st = ppbc_pkg::ST_TA;
                        end
                        // Only index zero is implemented; others read zero.
                        s_nxt.shf = (hdrNxt[4:0] == ppbc_pkg::CTRL_REG_INDEX)
                                  ? ctrl : 16'h0000;
                    end
                end
                ppbc_pkg::ST_TA:
                begin
                    s_nxt.cnt = s_r.cnt + 6'h01;
                    if (s_r.cnt == 6'h00 && isRead)
                    begin
                        s_nxt.mdo   = 1'b0;
                        s_nxt.mdoeN = 1'b0;
                    end
                    else if (s_r.cnt != 6'h00)
                    begin
                        s_nxt.st  = ppbc_pkg::ST_DATA;
                        s_nxt.cnt = '0;
                        if (isRead)
                        begin
                            s_nxt.mdo = s_r.shf[15];
                            s_nxt.shf = {s_r.shf[14:0], 1'b0};
                        end
                    end
                end
                ppbc_pkg::ST_DATA:
                begin
                    s_nxt.cnt = s_r.cnt + 6'h01;
                    if (isRead)
                    begin
                        s_nxt.mdo = s_r.shf[15];
                        s_nxt.shf = {s_r.shf[14:0], 1'b0};
                    end
                    else
                    begin
                        s_nxt.shf = {s_r.shf[14:0], mdioIn};
                    end
                    if (s_r.cnt == ppbc_pkg::DATA_LAST)
                    begin
                        s_nxt.st    = ppbc_pkg::ST_PRE;
                        s_nxt.cnt   = '0;
                        s_nxt.mdo   = 1'b1;
                        s_nxt.mdoeN = 1'b1;
                        s_nxt.wrEn  = !isRead && isOurs &&
                            s_r.hdr[4:0] == ppbc_pkg::CTRL_REG_INDEX;
                        s_nxt.wrData = {s_r.shf[14:0], mdioIn};
                    end
                end
                ppbc_pkg::ST_IDLE:
                begin
                    s_nxt.cnt = s_r.cnt + 6'h01;
                    if (s_r.cnt == ppbc_pkg::DATA_LAST + 6'h02)
                    begin
                        s_nxt.st  = ppbc_pkg::ST_PRE;
                        s_nxt.cnt = '0;
                    end
                end
                default:
                begin
                    s_nxt.st  = ppbc_pkg::ST_PRE;
                    s_nxt.cnt = '0;
                end
            endcase
        end
        s_nxt.ane  = ctrl[ppbc_pkg::BIT_AUTONEG];
        s_nxt.spd  = ctrl[ppbc_pkg::BIT_AUTONEG]
                   ? anSpeed100 : ctrl[ppbc_pkg::BIT_SPEED];
        s_nxt.dup  = ctrl[ppbc_pkg::BIT_AUTONEG]
                   ? anFullDuplex : ctrl[ppbc_pkg::BIT_DUPLEX];
        s_nxt.pwd  = ctrl[ppbc_pkg::BIT_POWER_DOWN];
        s_nxt.anr  = anRestartPulse;
        s_nxt.srst = softResetPulse;
        s_nxt.txLine = fabricTxActive & ~ctrl[ppbc_pkg::BIT_LOOPBACK]
                     & ~ctrl[ppbc_pkg::BIT_POWER_DOWN];
        s_nxt.rxLoop = fabricTxActive & ctrl[ppbc_pkg::BIT_LOOPBACK];
        s_nxt.col  = fabricTxActive & ctrl[ppbc_pkg::BIT_COL_TEST];
    end

    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            s_r       <= '0;
            s_r.st    <= ppbc_pkg::ST_PRE;
            s_r.mdo   <= 1'b1;
            s_r.mdoeN <= 1'b1;
        end
        else
        begin
            s_r <= s_nxt;
        end
    end

    assign mdioOut        = s_r.mdo;
    assign mdioOe_n       = s_r.mdoeN;
    assign lineTxEnable   = s_r.txLine;
    assign fabricRxLoop   = s_r.rxLoop;
    assign collision      = s_r.col;
    assign speed100       = s_r.spd;
    assign fullDuplex     = s_r.dup;
    assign autonegEnable  = s_r.ane;
    assign autonegRestart = s_r.anr;
    assign powerDown      = s_r.pwd;
    assign portSoftReset  = s_r.srst;

    a_loop_no_line: assert property (
        @(posedge ref_clk) disable iff (rst)
        ctrl[ppbc_pkg::BIT_LOOPBACK] && fabricTxActive
        |=> fabricRxLoop && !lineTxEnable)
        else $error("Loopback traffic reached the line.");
    a_forced_speed: assert property (
        @(posedge ref_clk) disable iff (rst)
        !ctrl[ppbc_pkg::BIT_AUTONEG]
        |=> speed100 == $past(ctrl[ppbc_pkg::BIT_SPEED])
            && fullDuplex == $past(ctrl[ppbc_pkg::BIT_DUPLEX]))
        else $error("Forced speed or duplex not applied.");
    a_autoneg_override: assert property (
        @(posedge ref_clk) disable iff (rst)
        ctrl[ppbc_pkg::BIT_AUTONEG]
        |=> autonegEnable && speed100 == $past(anSpeed100)
            && fullDuplex == $past(anFullDuplex))
        else $error("Forced bits not overridden.");
    a_collision_test: assert property (
        @(posedge ref_clk) disable iff (rst)
        collision == ($past(fabricTxActive)
            && $past(ctrl[ppbc_pkg::BIT_COL_TEST])))
        else $error("Collision indication wrong.");
    a_read_drive: assert property (
        @(posedge ref_clk) disable iff (rst)
        s_r.st == ppbc_pkg::ST_PRE |-> mdioOe_n)
        else $error("Line driven outside a read.");
endmodule : ppbc_port_control

// file: hdl/ppbc_pkg.sv
// Constants and types shared by the port transceiver control block.
package ppbc_pkg;
    localparam logic [4:0]  CTRL_REG_INDEX   = 5'h00;
    localparam int          BIT_SOFT_RESET   = 15;
    localparam int          BIT_LOOPBACK     = 14;
    localparam int          BIT_SPEED        = 13;
    localparam int          BIT_AUTONEG      = 12;
    localparam int          BIT_POWER_DOWN   = 11;
    localparam int          BIT_AN_RESTART   = 9;
    localparam int          BIT_DUPLEX       = 8;
    localparam int          BIT_COL_TEST     = 7;
    localparam logic [15:0] CTRL_RESET_VALUE = 16'h0000;
    localparam logic [15:0] CTRL_STORE_MASK  = 16'h7980;
    localparam logic [5:0]  PREAMBLE_LEN     = 6'h20;
    localparam logic [5:0]  HDR_LAST         = 6'h0C;
    localparam logic [5:0]  DATA_LAST        = 6'h0F;
    localparam logic [1:0]  OP_READ          = 2'h2;
    localparam logic [1:0]  OP_WRITE         = 2'h1;

    typedef enum logic [4:0] {
        ST_PRE  = 5'b00001,
        ST_HDR  = 5'b00010,
        ST_TA   = 5'b00100,
        ST_DATA = 5'b01000,
        ST_IDLE = 5'b10000
    } ppbc_state_t;
endpackage : ppbc_pkg

// file: hdl/ppbc_ctrl_reg.sv
// Control register storage with strap defaults, loader and self-clearing bits.
`timescale 1ns/1ps
module ppbc_ctrl_reg (
    input  wire logic        ref_clk,
    input  wire logic        rst,
    input  wire logic        autonegStrap,
    input  wire logic        speedStrap,
    input  wire logic        duplexStrap,
    input  wire logic        loadValid,
    input  wire logic [15:0] loadData,
    input  wire logic        wrEn,
    input  wire logic [15:0] wrData,
    output logic      [15:0] ctrl,
    output logic             softResetPulse,
    output logic             anRestartPulse
);
    typedef struct packed {
        logic        init;
        logic [15:0] ctrl;
        logic        srst;
        logic        anrs;
    } ppbc_creg_t;

    ppbc_creg_t  s_r;
    ppbc_creg_t  s_nxt;
    logic [15:0] dflt;

    always_comb
    begin
        dflt = ppbc_pkg::CTRL_RESET_VALUE;
        dflt[ppbc_pkg::BIT_SPEED]   = autonegStrap | speedStrap;
        dflt[ppbc_pkg::BIT_AUTONEG] = autonegStrap;
        dflt[ppbc_pkg::BIT_DUPLEX]  = ~autonegStrap & duplexStrap;
        s_nxt      = s_r;
        s_nxt.init = 1'b1;
        s_nxt.srst = 1'b0;
        s_nxt.anrs = 1'b0;
        if (!s_r.init)
        begin
            s_nxt.ctrl = dflt & ppbc_pkg::CTRL_STORE_MASK;
        end
        else if (loadValid)
        begin
            s_nxt.ctrl = loadData & ppbc_pkg::CTRL_STORE_MASK;
            s_nxt.srst = loadData[ppbc_pkg::BIT_SOFT_RESET];
            s_nxt.anrs = loadData[ppbc_pkg::BIT_AN_RESTART];
        end
        else if (wrEn && wrData[ppbc_pkg::BIT_SOFT_RESET])
        begin
            s_nxt.ctrl = dflt & ppbc_pkg::CTRL_STORE_MASK;
            s_nxt.srst = 1'b1;
        end
        else if (wrEn)
        begin
            s_nxt.ctrl = wrData & ppbc_pkg::CTRL_STORE_MASK;
            s_nxt.anrs = wrData[ppbc_pkg::BIT_AN_RESTART];
        end
    end

    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            s_r <= '0;
        end
        else
        begin
            s_r <= s_nxt;
        end
    end

    assign ctrl           = s_r.ctrl;
    assign softResetPulse = s_r.srst;
    assign anRestartPulse = s_r.anrs;

    a_reserved_zero: assert property (
        @(posedge ref_clk) disable iff (rst)
        (s_r.ctrl & ~ppbc_pkg::CTRL_STORE_MASK) == 16'h0000)
        else $error("Reserved or self-clearing bit stored.");
    a_loader_overwrite: assert property (
        @(posedge ref_clk) disable iff (rst)
        s_r.init && loadValid |=>
            s_r.ctrl == ($past(loadData) & ppbc_pkg::CTRL_STORE_MASK))
        else $error("Loader value not taken.");
    a_soft_reset_default: assert property (
        @(posedge ref_clk) disable iff (rst)
        s_r.init && !loadValid && wrEn && wrData[ppbc_pkg::BIT_SOFT_RESET]
        |=> s_r.srst && s_r.ctrl[ppbc_pkg::BIT_AUTONEG] == $past(autonegStrap)
            && !s_r.ctrl[ppbc_pkg::BIT_LOOPBACK] ##1 !s_r.srst)
        else $error("Soft reset did not restore defaults.");
    a_restart_self_clear: assert property (
        @(posedge ref_clk) disable iff (rst)
        s_r.anrs |=> !s_r.anrs)
        else $error("Restart bit did not clear itself.");
endmodule : ppbc_ctrl_reg

// file: test/ppbc_mgmt_host.sv
// Management host model that frames serial accesses on a pulled-up line.
`timescale 1ns/1ps
module ppbc_mgmt_host (
    input  wire logic ref_clk,
    input  wire logic mdioOut,
    input  wire logic mdioOe_n,
    output logic      mdc,
    output logic      mdioIn
);
    logic hostBit;
    logic hostOe;
    // The device wins while it drives; a released line floats high.
    assign mdioIn = !mdioOe_n ? mdioOut : (hostOe ? hostBit : 1'b1);
    // Receive-own-transmit lives in the switch MAC, outside this port.
    initial
    begin
        mdc = 1'b0;
        hostBit = 1'b1;
        hostOe = 1'b0;
    end
    // One bit: low phase with data set, sample, then the rising phase.
    task automatic oneBit(input logic b, input logic drv, output logic s);
        @(posedge ref_clk);
        #1;
        mdc = 1'b0;
        hostBit = b;
        hostOe = drv;
        repeat (2) @(posedge ref_clk);
        #1;
        s = mdioIn;
        mdc = 1'b1;
        @(posedge ref_clk);
    endtask : oneBit
    // Preamble, start, op, addresses, turnaround and sixteen data bits.
    task automatic frame(input logic [1:0] op, input logic [4:0] pa,
                         input logic [4:0] ra, input logic [15:0] wd,
                         output logic [15:0] rd);
        logic [47:0] hdr;
        logic        s;
        logic        rdOp;
        rdOp = op == ppbc_pkg::OP_READ;
        hdr = {32'hFFFFFFFF, 2'h1, op, pa, ra, 2'h2};
        for (int i = 47; i >= 0; i--)
            oneBit(hdr[i], !(rdOp && i < 2), s);
        for (int i = 15; i >= 0; i--)
        begin
            oneBit(wd[i], !rdOp, s);
            rd[i] = s;
        end
        @(posedge ref_clk);
        #1;
        mdc = 1'b0;
        hostOe = 1'b0;
    endtask : frame
endmodule : ppbc_mgmt_host

// file: test/ppbc_port_control_bench.sv
// Self-checking bench for the port transceiver control block.
`timescale 1ns/1ps
module ppbc_port_control_bench;
    localparam logic [4:0] PHY = 5'h03;
    localparam logic [1:0] WR  = ppbc_pkg::OP_WRITE;
    localparam logic [1:0] RD  = ppbc_pkg::OP_READ;
    logic        ref_clk, rst, mdc, mdioIn, mdioOut, mdioOe_n;
    logic [2:0]  strap;
    logic        loadValid, anSpeed100, anFullDuplex, fabricTxActive;
    logic [15:0] loadData, rd, d;
    logic        lineTxEnable, fabricRxLoop, collision, speed100;
    logic        fullDuplex, autonegEnable, autonegRestart, powerDown;
    logic        portSoftReset;
    int          badCount = 0, cmpCount = 0, rstPulses = 0, anPulses = 0;
    int          n;

    ppbc_port_control ppbc_port_control_inst (
        .ref_clk(ref_clk), .rst(rst), .phyAddr(PHY), .mdc(mdc),
        .mdioIn(mdioIn), .mdioOut(mdioOut), .mdioOe_n(mdioOe_n),
        .autonegStrap(strap[2]), .speedStrap(strap[1]),
        .duplexStrap(strap[0]), .loadValid(loadValid),
        .loadData(loadData), .anSpeed100(anSpeed100),
        .anFullDuplex(anFullDuplex), .fabricTxActive(fabricTxActive),
        .lineTxEnable(lineTxEnable), .fabricRxLoop(fabricRxLoop),
        .collision(collision), .speed100(speed100),
        .fullDuplex(fullDuplex), .autonegEnable(autonegEnable),
        .autonegRestart(autonegRestart), .powerDown(powerDown),
        .portSoftReset(portSoftReset));
    ppbc_mgmt_host ppbc_mgmt_host_inst (
        .ref_clk(ref_clk), .mdioOut(mdioOut), .mdioOe_n(mdioOe_n),
        .mdc(mdc), .mdioIn(mdioIn));

    initial
    begin
        ref_clk = 1'b0;
        forever #20 ref_clk = ~ref_clk;
    end
    // Counts the one-cycle pulses so a lost or doubled pulse shows.
    always @(posedge ref_clk)
    begin
        rstPulses <= rstPulses + int'(portSoftReset);
        anPulses <= anPulses + int'(autonegRestart);
    end

    task automatic check(input string nm, input logic [15:0] exp,
                         input logic [15:0] got);
        cmpCount++;
        if (got !== exp)
        begin
            badCount++;
            $display("mismatch %s expected %h seen %h", nm, exp, got);
        end
    endtask : check
    function automatic logic [15:0] dflt(input logic [2:0] s);
        dflt = 16'h0000;
        dflt[13] = s[2] | s[1];
        dflt[12] = s[2];
        dflt[8] = !s[2] & s[0];
    endfunction : dflt
    task automatic xfer(input logic [1:0] op, input logic [4:0] pa,
                        input logic [4:0] ra, input logic [15:0] wd);
        ppbc_mgmt_host_inst.frame(op, pa, ra, wd, rd);
    endtask : xfer
    task automatic rdChk(input logic [15:0] exp);
        xfer(RD, PHY, 5'h00, 16'h0000);
        check("ctrlRead", exp, rd);
    endtask : rdChk
    task automatic chkOut(input logic [15:0] v);
        fabricTxActive = 1'b1;
        repeat (3) @(posedge ref_clk);
        #1;
        check("autoneg", 16'(v[12]), 16'(autonegEnable));
        check("pdown", 16'(v[11]), 16'(powerDown));
        check("speed", 16'(v[12] ? anSpeed100 : v[13]),
              16'(speed100));
        check("duplex", 16'(v[12] ? anFullDuplex : v[8]),
              16'(fullDuplex));
        check("lineTx", 16'(!v[14] && !v[11]), 16'(lineTxEnable));
        check("loop", 16'(v[14]), 16'(fabricRxLoop));
        check("coll", 16'(v[7]), 16'(collision));
        fabricTxActive = 1'b0;
        repeat (3) @(posedge ref_clk);
        #1;
        check("idle", 16'h0000,
              {13'h0000, lineTxEnable, fabricRxLoop, collision});
    endtask : chkOut
    task automatic doReset;
        rst = 1'b1;
        repeat (20) @(posedge ref_clk);
        #1;
        check("inReset", 16'h0008, {12'h000, mdioOe_n, autonegEnable,
                                    powerDown, portSoftReset});
        rst = 1'b0;
        repeat (4) @(posedge ref_clk);
        #1;
        rdChk(dflt(strap));
        chkOut(dflt(strap));
    endtask : doReset
    task automatic reportAndStop;
        $display("checks %0d mismatches %0d", cmpCount, badCount);
        if (badCount == 0 && cmpCount > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : reportAndStop

    initial
    begin
        #2000000;
        badCount++;
        reportAndStop();
    end
    initial
    begin
        n = int'($urandom(32'hEA583206));
        {loadValid, anSpeed100, anFullDuplex, fabricTxActive} = 4'h0;
        loadData = 16'h0000;
        strap = 3'h5;
        doReset();
        for (int k = 0; k < 8; k++)
        begin
            strap = 3'(k);
            n = rstPulses;
            xfer(WR, PHY, 5'h00, 16'hC980);
            rdChk(dflt(strap));
            check("softRst", 16'h0001, 16'(rstPulses - n));
            chkOut(dflt(strap));
        end
        for (int k = 0; k < 12; k++)
        begin
            d = k == 0 ? 16'h7FFF : k == 1 ? 16'h0000 : 16'($urandom());
            d[15] = 1'b0;
            if (d[11])
                d[12] = 1'b0;
            {anSpeed100, anFullDuplex} = 2'($urandom());
            n = anPulses;
            xfer(WR, PHY, 5'h00, d);
            rdChk(d & ppbc_pkg::CTRL_STORE_MASK);
            check("restart", 16'(d[9]), 16'(anPulses - n));
            chkOut(d);
        end
        xfer(WR, PHY, 5'h01, 16'hFFFF);
        xfer(WR, PHY ^ 5'h01, 5'h00, 16'hFFFF);
        // An undefined operation code to our address must be ignored.
        xfer(2'h3, PHY, 5'h00, 16'hFFFF);
        rdChk(d & ppbc_pkg::CTRL_STORE_MASK);
        xfer(RD, PHY, 5'h01, 16'h0000);
        check("otherIndex", 16'h0000, rd);
        xfer(RD, PHY ^ 5'h01, 5'h00, 16'h0000);
        check("otherPhy", 16'hFFFF, rd);
        d = 16'($urandom()) & 16'h7DFF;
        @(posedge ref_clk);
        #1;
        loadData = d;
        loadValid = 1'b1;
        @(posedge ref_clk);
        #1;
        loadValid = 1'b0;
        rdChk(d & ppbc_pkg::CTRL_STORE_MASK);
        chkOut(d);
        strap = 3'h2;
        doReset();
        reportAndStop();
    end
endmodule : ppbc_port_control_bench
